// ==== logic/ckg_defs.vh ====
// constants for the clock generator: register map, fields, timing
// assumes a 10 MHz system clock and an 8-bit register file on the bus
`ifndef CKG_DEFS_VH
`define CKG_DEFS_VH

// word addresses of the registers
`define CKG_A_CLKSRC 3'h0
`define CKG_A_MISC 3'h1
`define CKG_A_PRE 3'h2
`define CKG_A_TAPSEL 3'h3
`define CKG_A_WDCTL 3'h4
`define CKG_A_WDKEY 3'h5

// clock_source_control fields
`define CKG_B_CPUSEL 7
`define CKG_B_EXTDET 6
`define CKG_B_EXTEN 5
`define CKG_B_BIAS 4
`define CKG_B_XSP 3
`define CKG_B_RSP 2
`define CKG_B_XEN 1
`define CKG_B_REN 0

// misc_clock_options fields
`define CKG_B_RCPA 3
`define CKG_B_DEB 2
`define CKG_B_XOUT 1
`define CKG_B_COUT 0

// prescaler_reset_control field
`define CKG_B_PRECLR 0

// field reset values
`define CKG_RV_CPUSEL 1'b0
`define CKG_RV_EXTEN 1'b0
`define CKG_RV_BIAS 1'b1
`define CKG_RV_XEN 1'b0
`define CKG_RV_REN 1'b1
`define CKG_RV_SP 1'b1
`define CKG_RV_TAP 3'h0

// cpu clock source codes
`define CKG_SRC_RC 2'h0
`define CKG_SRC_EXT 2'h1
`define CKG_SRC_32K 2'h2

// timing
`define CKG_CLK_KHZ 10000
`define CKG_T_RSTA_US 5000
`define CKG_T_RSTB_US 20
`define CKG_XTAL_MASK 16'h8000
`define CKG_RC_START_EDGES 5'h10
`define CKG_EXT_LOSS_CYC 7'h40
`define CKG_WD_LIMIT 4'h8
`define CKG_WD_KEY1 8'h0A
`define CKG_WD_KEY2 8'h03

// low prescaler taps (bit k toggles at 32768 / 2^(k+1) Hz)
`define CKG_LP_DEB_SLOW 6
`define CKG_LP_DEB_FAST 1
`define CKG_LP_WD_TAP 12

`endif

// ==== logic/ckg_clock_gen.v ====
// clock generator: source select, prescalers, watchdog, pin outputs
// assumes oscillator and pin inputs are asynchronous to clk and much
// slower than 10 MHz; halt and sleep come from logic on clk
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ckg_defs.vh"

module ckg_clock_gen #(
    parameter REV_A = 1,
    parameter [15:0] RST_HOLD_A_CYC =
        (`CKG_T_RSTA_US * `CKG_CLK_KHZ + 999) / 1000
) (
    input wire clk,
    input wire arst_n,
    input wire [2:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire rc_clk_in,
    input wire xtal_clk_in,
    input wire ext_clk_in,
    input wire reset_pin,
    input wire porta0_in,
    input wire halt,
    input wire sleep,
    output reg cpu_clk,
    output reg clk_32k,
    output reg [7:0] hp_taps,
    output reg [14:0] lp_taps,
    output reg debounce_clk,
    output reg rc_osc_on,
    output reg rc_bias_on,
    output reg xtal_osc_on,
    output reg ext_clk_on,
    output reg pb2_out,
    output reg pb2_oe,
    output reg pb3_out,
    output reg pb3_oe,
    output reg int_reset,
    output reg wd_reset
);

localparam [15:0] RST_HOLD_B_CYC =
    (`CKG_T_RSTB_US * `CKG_CLK_KHZ + 999) / 1000;

function rise;
    input cur;
    input prev;
    begin
        rise = cur & ~prev;
    end
endfunction

// two-stage synchronisers, then one more stage for edge detection
reg [4:0] sync1_r;
reg [4:0] sync2_r;
reg [4:0] prev_r;
wire rc_s = sync2_r[0];
wire xtal_s = sync2_r[1];
wire ext_s = sync2_r[2];
wire rpin_s = sync2_r[3];
wire pa0_s = sync2_r[4];

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        sync1_r <= 5'h00;
        sync2_r <= 5'h00;
        prev_r <= 5'h00;
    end else begin
        sync1_r <= {porta0_in, reset_pin, ext_clk_in, xtal_clk_in, rc_clk_in};
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
    end
end

wire rc_edge = rise(rc_s, prev_r[0]);
wire xtal_edge = rise(xtal_s, prev_r[1]);
wire ext_edge = rise(ext_s, prev_r[2]);

// register state
reg cpusel_r;
reg ext_en_r;
reg bias_r;
reg xtal_en_r;
reg rc_en_r;
reg xtal_sp_r;
reg rc_sp_r;
reg ext_det_r;
reg rcpa_r;
reg deb_r;
reg xout_r;
reg cout_r;
reg [2:0] tap_sel_r;
reg wd_en_r;
reg wd_key_ok_r;
reg [3:0] wd_cnt_r;
reg [15:0] xtal_cnt_r;
reg [4:0] rc_cnt_r;
reg [6:0] ext_loss_r;
reg [7:0] hp_cnt_r;
reg [14:0] lp_cnt_r;
reg clk32_prev_r;
reg wd_tap_prev_r;
reg [1:0] src_r;
reg [15:0] rst_hold_r;

// bus handshake: one wait state; a write lands at the edge that sees
// waitrequest low, the same edge at which the master completes it
wire req = (read | write) & waitrequest;
wire wr = write & ~waitrequest;
wire [7:0] wbyte = writedata[7:0];
wire wr_clk = wr & (address == `CKG_A_CLKSRC) & ~sleep;
wire wr_misc = wr & (address == `CKG_A_MISC) & ~sleep;
wire wr_pre = wr & (address == `CKG_A_PRE);
wire wr_tap = wr & (address == `CKG_A_TAPSEL);
wire wr_wdctl = wr & (address == `CKG_A_WDCTL);
wire wr_wdkey = wr & (address == `CKG_A_WDKEY);

wire rc_run = rc_en_r & ~sleep;
wire clk32_lvl = xtal_en_r ? xtal_s : hp_cnt_r[tap_sel_r];
wire clk32_edge = rise(clk32_lvl, clk32_prev_r);
wire lp_clr = wr_pre & wbyte[`CKG_B_PRECLR];
wire wd_tap = lp_cnt_r[`CKG_LP_WD_TAP];
wire wd_tick = rise(wd_tap, wd_tap_prev_r);

reg [7:0] rd_byte;
always @* begin
    case (address)
        `CKG_A_CLKSRC: rd_byte = {cpusel_r, ext_det_r, ext_en_r, bias_r,
                                  xtal_sp_r, rc_sp_r, xtal_en_r, rc_en_r};
        `CKG_A_MISC: rd_byte = {4'h0, rcpa_r, deb_r, xout_r, cout_r};
        `CKG_A_TAPSEL: rd_byte = {5'h00, tap_sel_r};
        `CKG_A_WDCTL: rd_byte = {7'h00, wd_en_r};
        `CKG_A_WDKEY: rd_byte = {4'h0, wd_cnt_r};
        default: rd_byte = 8'h00;
    endcase
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
    end else begin
        waitrequest <= ~req;
        if (req && read) begin
            readdata <= {24'h000000, rd_byte};
        end
    end
end

// clock_source_control and misc_clock_options
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cpusel_r <= `CKG_RV_CPUSEL;
        ext_en_r <= `CKG_RV_EXTEN;
        bias_r <= `CKG_RV_BIAS;
        xtal_en_r <= `CKG_RV_XEN;
        rc_en_r <= `CKG_RV_REN;
        rcpa_r <= 1'b0;
        deb_r <= 1'b0;
        xout_r <= 1'b0;
        cout_r <= 1'b0;
        tap_sel_r <= `CKG_RV_TAP;
    end else begin
        if (sleep) begin
            // sleep holds the sleep-reset fields at their reset values
            cpusel_r <= `CKG_RV_CPUSEL;
            xtal_en_r <= `CKG_RV_XEN;
            rc_en_r <= `CKG_RV_REN;
            rcpa_r <= 1'b0;
            deb_r <= 1'b0;
            xout_r <= 1'b0;
            cout_r <= 1'b0;
        end else begin
            if (wr_clk) begin
                cpusel_r <= wbyte[`CKG_B_CPUSEL];
                ext_en_r <= wbyte[`CKG_B_EXTEN];
                bias_r <= wbyte[`CKG_B_BIAS];
                // crystal enable cannot be set while external clock active
                if (!(wbyte[`CKG_B_XEN] && (ext_det_r || ext_en_r))) begin
                    xtal_en_r <= wbyte[`CKG_B_XEN];
                end
            end
            if (wr_clk) begin
                rc_en_r <= wbyte[`CKG_B_REN];
            end else if (rcpa_r && pa0_s) begin
                rc_en_r <= 1'b1;
            end
            if (wr_misc) begin
                rcpa_r <= wbyte[`CKG_B_RCPA];
                deb_r <= wbyte[`CKG_B_DEB];
                xout_r <= wbyte[`CKG_B_XOUT];
                cout_r <= wbyte[`CKG_B_COUT];
            end
        end
        if (wr_tap) begin
            tap_sel_r <= wbyte[2:0];
        end
    end
end

// external clock detection: seen edges keep it alive, silence drops it
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        ext_det_r <= 1'b0;
        ext_loss_r <= 7'h00;
    end else begin
        if (ext_en_r && ext_edge) begin
            ext_det_r <= 1'b1;
            ext_loss_r <= `CKG_EXT_LOSS_CYC;
        end else if (ext_loss_r != 7'h00) begin
            ext_loss_r <= ext_loss_r - 7'h01;
        end else begin
            ext_det_r <= 1'b0;
        end
    end
end

// start phases of the two oscillators
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        xtal_sp_r <= `CKG_RV_SP;
        xtal_cnt_r <= 16'h0000;
        rc_sp_r <= `CKG_RV_SP;
        rc_cnt_r <= 5'h00;
    end else begin
        if (sleep || !xtal_en_r) begin
            xtal_sp_r <= `CKG_RV_SP;
            xtal_cnt_r <= 16'h0000;
        end else if (xtal_sp_r && xtal_edge) begin
            if (xtal_cnt_r == `CKG_XTAL_MASK - 16'h0001) begin
                xtal_sp_r <= 1'b0;
            end
            xtal_cnt_r <= xtal_cnt_r + 16'h0001;
        end
        if (!rc_run) begin
            rc_sp_r <= `CKG_RV_SP;
            rc_cnt_r <= 5'h00;
        end else if (rc_sp_r && rc_edge) begin
            if (rc_cnt_r == `CKG_RC_START_EDGES - 5'h01) begin
                rc_sp_r <= 1'b0;
            end
            rc_cnt_r <= rc_cnt_r + 5'h01;
        end
    end
end

// prescalers; a stopped rc with no crystal leaves the 32 kHz tap still
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        hp_cnt_r <= 8'h00;
        lp_cnt_r <= 15'h0000;
        clk32_prev_r <= 1'b0;
    end else begin
        if (rc_run && rc_edge) begin
            hp_cnt_r <= hp_cnt_r + 8'h01;
        end
        clk32_prev_r <= clk32_lvl;
        if (lp_clr) begin
            lp_cnt_r <= 15'h0000;
        end else if (clk32_edge) begin
            lp_cnt_r <= lp_cnt_r + 15'h0001;
        end
    end
end

// watchdog: eight ticks of a 4 Hz tap give two seconds
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wd_en_r <= 1'b0;
        wd_key_ok_r <= 1'b0;
        wd_cnt_r <= 4'h0;
        wd_tap_prev_r <= 1'b0;
        wd_reset <= 1'b0;
    end else begin
        wd_tap_prev_r <= wd_tap;
        if (wr_wdctl && wbyte[0]) begin
            wd_en_r <= 1'b1; // only power-on can disable it
        end
        if (wr_wdkey) begin
            wd_key_ok_r <= (wbyte == `CKG_WD_KEY1);
        end
        if (wr_wdkey && wd_key_ok_r && wbyte == `CKG_WD_KEY2) begin
            wd_cnt_r <= 4'h0;
        end else if (wd_en_r && wd_tick && wd_cnt_r != `CKG_WD_LIMIT) begin
            wd_cnt_r <= wd_cnt_r + 4'h1;
        end
        wd_reset <= wd_en_r && (wd_cnt_r == `CKG_WD_LIMIT);
    end
end

// cpu clock: switch source only while both levels are low
reg [1:0] tgt;
reg cur_lvl;
reg tgt_lvl;
always @* begin
    if (!cpusel_r) begin
        tgt = `CKG_SRC_RC;
    end else if (ext_en_r) begin
        tgt = `CKG_SRC_EXT;
    end else begin
        tgt = `CKG_SRC_32K;
    end
    case (src_r)
        `CKG_SRC_RC: cur_lvl = rc_s & rc_run;
        `CKG_SRC_EXT: cur_lvl = ext_s;
        default: cur_lvl = clk32_lvl;
    endcase
    case (tgt)
        `CKG_SRC_RC: tgt_lvl = rc_s & rc_run;
        `CKG_SRC_EXT: tgt_lvl = ext_s;
        default: tgt_lvl = clk32_lvl;
    endcase
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        src_r <= `CKG_SRC_RC;
        cpu_clk <= 1'b0;
    end else begin
        if (tgt != src_r && !cpu_clk && !tgt_lvl) begin
            src_r <= tgt;
        end
        // halt only takes effect on a low phase, so no runt pulse
        if (halt && !cpu_clk) begin
            cpu_clk <= 1'b0;
        end else if (tgt != src_r && !cpu_clk) begin
            cpu_clk <= 1'b0;
        end else begin
            cpu_clk <= cur_lvl;
        end
    end
end

// reset pin stretch; counted on clk, so independent of the rc
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        rst_hold_r <= 16'h0000;
        int_reset <= 1'b0;
    end else begin
        if (rpin_s) begin
            rst_hold_r <= (REV_A != 0) ? RST_HOLD_A_CYC : RST_HOLD_B_CYC;
            int_reset <= 1'b1;
        end else if (rst_hold_r != 16'h0000) begin
            rst_hold_r <= rst_hold_r - 16'h0001;
            int_reset <= 1'b1;
        end else begin
            int_reset <= 1'b0;
        end
    end
end

// registered clock and pin outputs
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        clk_32k <= 1'b0;
        hp_taps <= 8'h00;
        lp_taps <= 15'h0000;
        debounce_clk <= 1'b0;
        rc_osc_on <= 1'b0;
        rc_bias_on <= 1'b0;
        xtal_osc_on <= 1'b0;
        ext_clk_on <= 1'b0;
        pb2_out <= 1'b0;
        pb2_oe <= 1'b0;
        pb3_out <= 1'b0;
        pb3_oe <= 1'b0;
    end else begin
        clk_32k <= clk32_lvl;
        hp_taps <= hp_cnt_r;
        lp_taps <= lp_cnt_r;
        debounce_clk <= deb_r ? lp_cnt_r[`CKG_LP_DEB_FAST] :
                        lp_cnt_r[`CKG_LP_DEB_SLOW];
        rc_osc_on <= rc_run;
        rc_bias_on <= bias_r;
        xtal_osc_on <= xtal_en_r & ~sleep;
        ext_clk_on <= ext_en_r;
        pb2_out <= cout_r & cpu_clk;
        pb2_oe <= cout_r;
        pb3_out <= xout_r & xtal_en_r & xtal_s;
        pb3_oe <= xout_r;
    end
end

endmodule

// ==== test/ckg_clock_gen_chk.sv ====
// checker for the clock generator: bus, gating, pins, reset hold
// assumes a reset hold of about 20 cycles set at the instance
`timescale 1ns/10ps
`include "ckg_defs.vh"
module ckg_clock_gen_chk (
    input wire clk,
    input wire arst_n,
    input wire [2:0] address,
    input wire read,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire halt,
    input wire sleep,
    input wire reset_pin,
    input wire cpu_clk,
    input wire [14:0] lp_taps,
    input wire rc_osc_on,
    input wire rc_bias_on,
    input wire xtal_osc_on,
    input wire ext_clk_on,
    input wire pb2_out,
    input wire pb2_oe,
    input wire pb3_out,
    input wire pb3_oe,
    input wire int_reset
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_por;
        $rose(arst_n) |=> rc_osc_on && rc_bias_on;
    endproperty
    a_por: assert property (p_por) else $error("rc off after reset");
    property p_pre;
        $fell(waitrequest) && read && address == `CKG_A_PRE
            |-> readdata == 32'h0;
    endproperty
    a_pre: assert property (p_pre) else $error("clear bit read 1");
    property p_halt;
        halt[*3] |-> !cpu_clk;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu clock in halt");
    property p_pb2;
        halt[*5] ##0 pb2_oe |-> !pb2_out;
    endproperty
    a_pb2: assert property (p_pb2) else $error("pin clock in halt");
    property p_pb3;
        (!xtal_osc_on)[*3] ##0 pb3_oe |-> !pb3_out;
    endproperty
    a_pb3: assert property (p_pb3) else $error("crystal pin not 0");
    property p_xref;
        ext_clk_on && !xtal_osc_on |=> !xtal_osc_on;
    endproperty
    a_xref: assert property (p_xref) else $error("crystal on");
    property p_sleep;
        sleep[*3] |-> !rc_osc_on;
    endproperty
    a_sleep: assert property (p_sleep) else $error("rc on in sleep");
    // a jump other than +1 or to zero means a broken divider
    property p_lp;
        $changed(lp_taps) |-> lp_taps == $past(lp_taps) + 15'h1
            || lp_taps == 15'h0;
    endproperty
    a_lp: assert property (p_lp) else $error("low prescaler jump");
    property p_rst;
        reset_pin[*4] ##1 !reset_pin |-> int_reset[*8] ##[1:60] !int_reset;
    endproperty
    a_rst: assert property (p_rst) else $error("reset hold wrong");
endmodule

bind ckg_clock_gen ckg_clock_gen_chk u_chk (.clk(clk), .arst_n(arst_n),
    .address(address), .read(read), .readdata(readdata),
    .waitrequest(waitrequest), .halt(halt), .sleep(sleep),
    .reset_pin(reset_pin), .cpu_clk(cpu_clk), .lp_taps(lp_taps),
    .rc_osc_on(rc_osc_on), .rc_bias_on(rc_bias_on),
    .xtal_osc_on(xtal_osc_on), .ext_clk_on(ext_clk_on),
    .pb2_out(pb2_out), .pb2_oe(pb2_oe), .pb3_out(pb3_out),
    .pb3_oe(pb3_oe), .int_reset(int_reset));

// ==== test/tb_top.sv ====
// testbench for the clock generator: register bus, pins, reset pin
// assumes one 10 MHz clock; oscillators are made from it, far slower
`timescale 1ns/10ps
`include "ckg_defs.vh"
module tb_top;
    logic clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [2:0] address = 3'h0;
    logic [31:0] writedata = 32'h0;
    logic rc_clk_in = 1'b0, xtal_clk_in = 1'b0, ext_clk_in = 1'b0;
    logic reset_pin = 1'b0, porta0_in = 1'b0, halt = 1'b0, sleep = 1'b0;
    logic rc_run = 1'b0, ext_run = 1'b0;
    logic [3:0] div = 4'h0;
    logic [7:0] rd, hp0;
    logic [14:0] lp0;
    wire [31:0] readdata;
    wire [7:0] hp_taps;
    wire [14:0] lp_taps;
    wire waitrequest, cpu_clk, clk_32k, debounce_clk, rc_osc_on;
    wire rc_bias_on, xtal_osc_on, ext_clk_on, pb2_out, pb2_oe, pb3_out;
    wire pb3_oe, int_reset, wd_reset;
    int mismatches = 0;
    int checks = 0;
    int n, m, q;

    always #50 clk = ~clk;
    always @(posedge clk) begin
        div <= div + 4'h1;
        rc_clk_in <= rc_run & div[1];
        xtal_clk_in <= div[3];
        ext_clk_in <= ext_run & div[2];
    end

    ckg_clock_gen #(.REV_A(1), .RST_HOLD_A_CYC(16'h0014)) uut (
        .clk(clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rc_clk_in(rc_clk_in),
        .xtal_clk_in(xtal_clk_in), .ext_clk_in(ext_clk_in),
        .reset_pin(reset_pin), .porta0_in(porta0_in), .halt(halt),
        .sleep(sleep), .cpu_clk(cpu_clk), .clk_32k(clk_32k),
        .hp_taps(hp_taps), .lp_taps(lp_taps), .debounce_clk(debounce_clk),
        .rc_osc_on(rc_osc_on), .rc_bias_on(rc_bias_on),
        .xtal_osc_on(xtal_osc_on), .ext_clk_on(ext_clk_on),
        .pb2_out(pb2_out), .pb2_oe(pb2_oe), .pb3_out(pb3_out),
        .pb3_oe(pb3_oe), .int_reset(int_reset), .wd_reset(wd_reset));

    task finish_test;
        begin
            if (mismatches == 0 && checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask

    task chk8(input logic [7:0] got, input logic [7:0] exp);
        begin
            checks++;
            if (got !== exp) begin
                mismatches++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task chk1(input logic got, input logic exp);
        begin
            checks++;
            if (got !== exp) begin
                mismatches++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // one edge first, so a release never meets a new request
    task acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int k;
        begin
            @(posedge clk);
            address <= a;
            writedata <= {24'h0, d};
            read <= ~wr;
            write <= wr;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (waitrequest !== 1'b0 && k < 20);
            if (k >= 20) begin
                mismatches++;
                finish_test;
            end
            rd = readdata[7:0];
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task rd_chk(input logic [2:0] a, input logic [7:0] m,
                input logic [7:0] e);
        begin
            acc(1'b0, a, 8'h00);
            chk8(rd & m, e);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(`CKG_A_CLKSRC, 8'hFF, 8'h1D);
        rd_chk(`CKG_A_MISC, 8'hFF, 8'h00);
        rd_chk(3'h7, 8'hFF, 8'h00);
        acc(1'b1, `CKG_A_WDCTL, 8'h01);
        rd_chk(`CKG_A_WDCTL, 8'h01, 8'h01);
        rc_run <= 1'b1;
        repeat (200) @(posedge clk);
        acc(1'b1, `CKG_A_MISC, 8'hFF);
        rd_chk(`CKG_A_MISC, 8'hFF, 8'h0F);
        chk1(pb3_oe & ~pb3_out, 1'b1);
        chk1(pb2_oe, 1'b1);
        hp0 = hp_taps;
        halt <= 1'b1;
        repeat (40) @(posedge clk);
        chk1(cpu_clk | pb2_out, 1'b0);
        chk1(hp_taps !== hp0, 1'b1);
        halt <= 1'b0;
        n = 0;
        m = 0;
        q = 0;
        repeat (60) begin
            @(posedge clk);
            if (pb2_out === 1'b1) n++;
            if (clk_32k === 1'b1) m++;
            if (debounce_clk === 1'b1) q++;
        end
        chk1(n > 0, 1'b1);
        chk1(m > 0 && m < 60, 1'b1);
        chk1(q > 0 && q < 60, 1'b1);
        acc(1'b1, `CKG_A_CLKSRC, 8'h93);
        rd_chk(`CKG_A_CLKSRC, 8'hF3, 8'h93);
        chk1(xtal_osc_on, 1'b1);
        acc(1'b1, `CKG_A_PRE, 8'h01);
        // clear lands at the completing edge, the tap output one later
        repeat (2) @(posedge clk);
        chk1(lp_taps < 15'h0008, 1'b1);
        rd_chk(`CKG_A_PRE, 8'hFF, 8'h00);
        acc(1'b1, `CKG_A_CLKSRC, 8'h31);
        acc(1'b1, `CKG_A_CLKSRC, 8'h33);
        rd_chk(`CKG_A_CLKSRC, 8'hA3, 8'h21);
        chk1(xtal_osc_on | ~ext_clk_on, 1'b0);
        ext_run <= 1'b1;
        repeat (40) @(posedge clk);
        rd_chk(`CKG_A_CLKSRC, 8'h42, 8'h40);
        ext_run <= 1'b0;
        repeat (200) @(posedge clk);
        rd_chk(`CKG_A_CLKSRC, 8'h40, 8'h00);
        acc(1'b1, `CKG_A_CLKSRC, 8'hA1);
        acc(1'b1, `CKG_A_CLKSRC, 8'hA0);
        repeat (4) @(posedge clk);
        lp0 = lp_taps;
        repeat (40) @(posedge clk);
        chk1(lp_taps === lp0, 1'b1);
        chk1(rc_osc_on, 1'b0);
        reset_pin <= 1'b1;
        repeat (6) @(posedge clk);
        reset_pin <= 1'b0;
        n = 0;
        while (int_reset !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk1(n >= 21 && n <= 28, 1'b1);
        acc(1'b1, `CKG_A_MISC, 8'h0F);
        acc(1'b1, `CKG_A_CLKSRC, 8'hA1);
        sleep <= 1'b1;
        repeat (10) @(posedge clk);
        chk1(rc_osc_on, 1'b0);
        acc(1'b1, `CKG_A_CLKSRC, 8'h10);
        sleep <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(`CKG_A_CLKSRC, 8'hB3, 8'h21);
        rd_chk(`CKG_A_MISC, 8'hFF, 8'h00);
        chk1(rc_osc_on, 1'b1);
        chk1(wd_reset, 1'b0);
        acc(1'b1, `CKG_A_WDKEY, 8'h0A);
        acc(1'b1, `CKG_A_WDKEY, 8'h03);
        rd_chk(`CKG_A_WDKEY, 8'h0F, 8'h00);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(`CKG_A_CLKSRC, 8'hF3, 8'h11);
        finish_test;
    end
endmodule
